// File: rtl/fault_diag_pkg.sv
package fault_diag_pkg;
  localparam int CLK_MHZ = 40;
  // Detection times in microseconds
  localparam int SHORT_TIME_US_0 = 10;
  localparam int SHORT_TIME_US_1 = 20;
  localparam int SHORT_CYC_0 = SHORT_TIME_US_0 * CLK_MHZ;
  localparam int SHORT_CYC_1 = SHORT_TIME_US_1 * CLK_MHZ;
  localparam int CNT_W = 11;
  localparam logic [11:0] CMD_ERROR_CLEAR = 12'hA53;
  localparam logic [2:0] VERDICT_RESET = 3'h0;
  localparam logic [2:0] VERDICT_PASS = 3'h3;
  localparam logic [2:0] VERDICT_FAIL = 3'h6;
  localparam int RESULT_W = 24;
  localparam int RED_LSB = 0;
  localparam int MID_LSB = 8;
  localparam int BLUE_LSB = 16;
  // Grayscale mode codes: period minus one is the late latch edge
  localparam logic [1:0] GS_MODE_12 = 2'h0;
  localparam logic [1:0] GS_MODE_10 = 2'h1;
  localparam logic [1:0] GS_MODE_8 = 2'h2;
  localparam logic [11:0] EARLY_EDGE = 12'h009;
  localparam logic [11:0] LATE_EDGE_12 = 12'hFFF;
  localparam logic [11:0] LATE_EDGE_10 = 12'h3FF;
  localparam logic [11:0] LATE_EDGE_8 = 12'h0FF;
  localparam logic [7:0] LOW_CURRENT_LIMIT_MA = 8'h0A;
  localparam logic LED_MASK_RESET = 1'b1;
endpackage

// File: rtl/led_driver_fault_diagnostics.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Short result bits: red 0-7 at 0-7, middle pins 8-15, blue 0-7 at 16-23.
// - Reset clears short verdict and per-pin short result.
// - Completed short check loads verdict 011b pass or 110b fail.
// - Short fail holds 110b and fault low until gone and cleared.
// - Current select bit 0 gives 20 uA, 1 gives 40 uA.
// - Time select bit 0 gives 10 us, 1 gives 20 us.
// - Reference short and open flags reset to zero.
// - Reference fault sets its flag, pulls fault low, held until gone and cleared.
// - Low current sets open flag, above 3 mA sets short flag.
// - Any reference fault forces 10 mA limit, released at once.
// - Thermal warning sets flag, pulls fault low, held until cool and cleared.
// - Shutdown disables outputs, sets flag, pulls fault low, held until cool and cleared.
// - Digital access works in shutdown; outputs resume once cooled.
// - Negate bits reset 0; toggle sets both and inverts detector results.
// - Early set latches at 9th grayscale edge, late set at last-but-one.
// - Self-test verdict resets 000b, then 011b good or 110b faulty.
// - Self-test fail pulls fault low and holds 110b until gone and cleared.
// - Command code A53h is error clear.
// - Error clear zeroes flags and short result only if fault gone.
// - Status flags drive fault pin; LED faults only when mask cleared.
module led_driver_fault_diagnostics
  import fault_diag_pkg::*;
#(
  parameter int RESULT_BITS = fault_diag_pkg::RESULT_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  input wire logic [11:0] CMD_CODE,
  input wire logic SHORT_CHECK_START,
  input wire logic SELFTEST_START,
  input wire logic NEGATE_TOGGLE,
  input wire logic SHORT_CHECK_CURRENT_SEL,
  input wire logic SHORT_CHECK_TIME_SEL,
  input wire logic LED_FAULT_MASK,
  input wire logic [1:0] GS_MODE,
  input wire logic GRAYSCALE_CLOCK,
  input wire logic [7:0] SHORT_SENSE_RED,
  input wire logic [7:0] SHORT_SENSE_MID,
  input wire logic [7:0] SHORT_SENSE_BLUE,
  input wire logic REF_BELOW_LOW,
  input wire logic REF_ABOVE_HIGH,
  input wire logic TEMP_WARN,
  input wire logic TEMP_SHUTDOWN,
  input wire logic SELFTEST_GOOD,
  input wire logic LED_FAULT,
  input wire logic [RESULT_BITS-1:0] OPEN_SENSE,
  input wire logic [RESULT_BITS-1:0] SHORT_SENSE,
  output logic [2:0] ADJACENT_SHORT_VERDICT,
  output logic [RESULT_BITS-1:0] ADJACENT_SHORT_PER_PIN_RESULT,
  output logic SHORT_CHECK_BUSY,
  output logic SHORT_CHECK_CURRENT_40UA,
  output logic REF_RESISTOR_SHORT_FLAG,
  output logic REF_RESISTOR_OPEN_FLAG,
  output logic CURRENT_FALLBACK,
  output logic THERMAL_WARNING_FLAG,
  output logic THERMAL_SHUTDOWN_FLAG,
  output logic OUTPUTS_ENABLE,
  output logic NEGATE_BIT_A,
  output logic NEGATE_BIT_B,
  output logic [2:0] DETECTOR_SELFTEST_VERDICT,
  output logic [RESULT_BITS-1:0] OPEN_RESULT_EARLY,
  output logic [RESULT_BITS-1:0] SHORT_RESULT_EARLY,
  output logic [RESULT_BITS-1:0] OPEN_RESULT_LATE,
  output logic [RESULT_BITS-1:0] SHORT_RESULT_LATE,
  output logic FAULT_N_OUT,
  output logic FAULT_N_OE
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic {IDLE, MEASURE} check_state_type;

  // Pins from outside the clock domain: three stages, agree on last two
  logic [2:0] sync_ref_low, sync_ref_high, sync_warn, sync_tsd, sync_grayscale_clock;
  logic ref_low, ref_high, warn, tsd, grayscale_clock_prev;
  logic next_ref_low, next_ref_high, next_warn, next_tsd;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_ref_low <= 3'h0;
      sync_ref_high <= 3'h0;
      sync_warn <= 3'h0;
      sync_tsd <= 3'h0;
      sync_grayscale_clock <= 3'h0;
      ref_low <= 1'b0;
      ref_high <= 1'b0;
      warn <= 1'b0;
      tsd <= 1'b0;
      grayscale_clock_prev <= 1'b0;
    end else begin
      sync_ref_low <= {sync_ref_low[1:0], REF_BELOW_LOW};
      sync_ref_high <= {sync_ref_high[1:0], REF_ABOVE_HIGH};
      sync_warn <= {sync_warn[1:0], TEMP_WARN};
      sync_tsd <= {sync_tsd[1:0], TEMP_SHUTDOWN};
      sync_grayscale_clock <= {sync_grayscale_clock[1:0], GRAYSCALE_CLOCK};
      ref_low <= next_ref_low;
      ref_high <= next_ref_high;
      warn <= next_warn;
      tsd <= next_tsd;
      if (sync_grayscale_clock[2] == sync_grayscale_clock[1]) begin
        grayscale_clock_prev <= sync_grayscale_clock[2];
      end
    end
  end

  function automatic logic agreed(input logic [2:0] s, input logic held);
    agreed = (s[2] == s[1]) ? s[2] : held;
  endfunction

  always_comb begin
    next_ref_low = agreed(sync_ref_low, ref_low);
    next_ref_high = agreed(sync_ref_high, ref_high);
    next_warn = agreed(sync_warn, warn);
    next_tsd = agreed(sync_tsd, tsd);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Grayscale counter and detector result latching
  logic grayscale_clock_rise;
  logic [11:0] gs_count, next_gs_count, late_edge;
  logic [RESULT_BITS-1:0] next_open_early, next_short_early, next_open_late, next_short_late;
  logic next_negate;
  logic clear_cmd;
  assign grayscale_clock_rise = (sync_grayscale_clock[2] == sync_grayscale_clock[1]) && sync_grayscale_clock[2] && !grayscale_clock_prev;
  assign clear_cmd = CMD_VALID && (CMD_CODE == CMD_ERROR_CLEAR);

  always_comb begin
    unique case (GS_MODE)
      GS_MODE_10: late_edge = LATE_EDGE_10;
      GS_MODE_8: late_edge = LATE_EDGE_8;
      default: late_edge = LATE_EDGE_12;
    endcase
    next_gs_count = gs_count;
    next_open_early = OPEN_RESULT_EARLY;
    next_short_early = SHORT_RESULT_EARLY;
    next_open_late = OPEN_RESULT_LATE;
    next_short_late = SHORT_RESULT_LATE;
    next_negate = NEGATE_BIT_A || NEGATE_TOGGLE;
    if (grayscale_clock_rise) begin
      // Counter holds the edge number within the period, 1 at the first edge
      next_gs_count = (gs_count >= late_edge) ? 12'h000 : gs_count + 12'h001;
      if (next_gs_count == EARLY_EDGE) begin
        next_open_early = OPEN_SENSE ^ {RESULT_BITS{NEGATE_BIT_A}};
        next_short_early = SHORT_SENSE ^ {RESULT_BITS{NEGATE_BIT_A}};
      end
      if (next_gs_count == late_edge) begin
        next_open_late = OPEN_SENSE ^ {RESULT_BITS{NEGATE_BIT_B}};
        next_short_late = SHORT_SENSE ^ {RESULT_BITS{NEGATE_BIT_B}};
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gs_count <= 12'h000;
      OPEN_RESULT_EARLY <= '0;
      SHORT_RESULT_EARLY <= '0;
      OPEN_RESULT_LATE <= '0;
      SHORT_RESULT_LATE <= '0;
      NEGATE_BIT_A <= 1'b0;
      NEGATE_BIT_B <= 1'b0;
    end else begin
      gs_count <= next_gs_count;
      OPEN_RESULT_EARLY <= next_open_early;
      SHORT_RESULT_EARLY <= next_short_early;
      OPEN_RESULT_LATE <= next_open_late;
      SHORT_RESULT_LATE <= next_short_late;
      NEGATE_BIT_A <= next_negate;
      NEGATE_BIT_B <= next_negate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Adjacent-pin short check
  check_state_type state, next_state;
  logic [CNT_W-1:0] timer, next_timer;
  logic [2:0] next_verdict;
  logic [RESULT_BITS-1:0] next_result, sensed;
  logic time_sel, next_time_sel;
  assign sensed = {SHORT_SENSE_BLUE, SHORT_SENSE_MID, SHORT_SENSE_RED};

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_time_sel = time_sel;
    next_verdict = ADJACENT_SHORT_VERDICT;
    next_result = ADJACENT_SHORT_PER_PIN_RESULT;
    unique case (state)
      IDLE: begin
        if (SHORT_CHECK_START) begin
          next_state = MEASURE;
          next_timer = '0;
          next_time_sel = SHORT_CHECK_TIME_SEL;
        end else if (clear_cmd && ADJACENT_SHORT_VERDICT != VERDICT_FAIL) begin
          next_verdict = VERDICT_RESET;
          next_result = '0;
        end else if (clear_cmd && sensed == '0) begin
          next_verdict = VERDICT_RESET;
          next_result = '0;
        end
      end
      MEASURE: begin
        next_timer = timer + 1'b1;
        // Time counts from the command; wider window suits slow LED capacitance
        if (int'(timer) + 1 >= (time_sel ? SHORT_CYC_1 : SHORT_CYC_0)) begin
          next_state = IDLE;
          next_result = sensed;
          // A held failure is never downgraded by a later pass
          if (sensed != '0 || ADJACENT_SHORT_VERDICT == VERDICT_FAIL) begin
            next_verdict = VERDICT_FAIL;
            next_result = sensed | ADJACENT_SHORT_PER_PIN_RESULT;
          end else begin
            next_verdict = VERDICT_PASS;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= IDLE;
      timer <= '0;
      time_sel <= 1'b0;
      ADJACENT_SHORT_VERDICT <= VERDICT_RESET;
      ADJACENT_SHORT_PER_PIN_RESULT <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      time_sel <= next_time_sel;
      ADJACENT_SHORT_VERDICT <= next_verdict;
      ADJACENT_SHORT_PER_PIN_RESULT <= next_result;
    end
  end

  assign SHORT_CHECK_BUSY = (state == MEASURE);
  assign SHORT_CHECK_CURRENT_40UA = SHORT_CHECK_CURRENT_SEL;

  ////////////////////////////////////////////////////////////////////////////////
  // Latched status flags; set wins over clear
  logic next_isf, next_iof, next_ptw, next_tef;
  logic [2:0] next_selftest;
  always_comb begin
    next_isf = REF_RESISTOR_SHORT_FLAG;
    next_iof = REF_RESISTOR_OPEN_FLAG;
    next_ptw = THERMAL_WARNING_FLAG;
    next_tef = THERMAL_SHUTDOWN_FLAG;
    next_selftest = DETECTOR_SELFTEST_VERDICT;
    if (clear_cmd) begin
      next_isf = 1'b0;
      next_iof = 1'b0;
      next_ptw = 1'b0;
      next_tef = 1'b0;
      // Pass code is status too, so a clear with no fault drops it as well
      if (SELFTEST_GOOD || DETECTOR_SELFTEST_VERDICT != VERDICT_FAIL) begin
        next_selftest = VERDICT_RESET;
      end
    end
    if (ref_high) next_isf = 1'b1;
    if (ref_low) next_iof = 1'b1;
    if (warn) next_ptw = 1'b1;
    if (tsd) next_tef = 1'b1;
    if (SELFTEST_START) begin
      // A held failure stays 110b until cleared
      next_selftest = (SELFTEST_GOOD && DETECTOR_SELFTEST_VERDICT != VERDICT_FAIL)
                      ? VERDICT_PASS : VERDICT_FAIL;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REF_RESISTOR_SHORT_FLAG <= 1'b0;
      REF_RESISTOR_OPEN_FLAG <= 1'b0;
      THERMAL_WARNING_FLAG <= 1'b0;
      THERMAL_SHUTDOWN_FLAG <= 1'b0;
      DETECTOR_SELFTEST_VERDICT <= VERDICT_RESET;
      CURRENT_FALLBACK <= 1'b0;
      OUTPUTS_ENABLE <= 1'b0;
      FAULT_N_OE <= 1'b0;
    end else begin
      REF_RESISTOR_SHORT_FLAG <= next_isf;
      REF_RESISTOR_OPEN_FLAG <= next_iof;
      THERMAL_WARNING_FLAG <= next_ptw;
      THERMAL_SHUTDOWN_FLAG <= next_tef;
      DETECTOR_SELFTEST_VERDICT <= next_selftest;
      // Follows live condition, not the flag, so current returns at once
      CURRENT_FALLBACK <= next_ref_low || next_ref_high;
      OUTPUTS_ENABLE <= !next_tsd;
      FAULT_N_OE <= next_isf || next_iof || next_ptw || next_tef
                    || next_verdict == VERDICT_FAIL || next_selftest == VERDICT_FAIL
                    || (LED_FAULT && !LED_FAULT_MASK);
    end
  end

  // Open drain: only ever drives low
  assign FAULT_N_OUT = 1'b0;
endmodule // led_driver_fault_diagnostics

// File: verif/fault_diag_checker.sv
`timescale 1ns/1ps
module fault_diag_checker
  import fault_diag_pkg::*;
#(
  parameter int RESULT_BITS = 24
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SHORT_CHECK_START,
  input wire logic SHORT_CHECK_TIME_SEL,
  input wire logic SHORT_CHECK_BUSY,
  input wire logic [7:0] SHORT_SENSE_RED,
  input wire logic [7:0] SHORT_SENSE_MID,
  input wire logic [7:0] SHORT_SENSE_BLUE,
  input wire logic [2:0] ADJACENT_SHORT_VERDICT,
  input wire logic [RESULT_BITS-1:0] ADJACENT_SHORT_PER_PIN_RESULT,
  input wire logic SELFTEST_START,
  input wire logic SELFTEST_GOOD,
  input wire logic [2:0] DETECTOR_SELFTEST_VERDICT,
  input wire logic NEGATE_TOGGLE,
  input wire logic NEGATE_BIT_A,
  input wire logic NEGATE_BIT_B,
  input wire logic FAULT_N_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic sel;
  logic next_sel;
  int cnt;
  int next_cnt;
  // Time select is captured only when a start is accepted
  always_comb begin
    next_sel = (SHORT_CHECK_START && !SHORT_CHECK_BUSY) ? SHORT_CHECK_TIME_SEL : sel;
    next_cnt = SHORT_CHECK_BUSY ? cnt + 1 : 0;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel <= 1'b0;
      cnt <= 0;
    end else begin
      sel <= next_sel;
      cnt <= next_cnt;
    end
  end
  ////////////////////////////////////////
  AST_VERDICT_CODE: assert property (ADJACENT_SHORT_VERDICT inside {3'h0, 3'h3, 3'h6})
    else $error("short verdict code illegal");
  AST_SELFTEST_CODE: assert property (DETECTOR_SELFTEST_VERDICT inside {3'h0, 3'h3, 3'h6})
    else $error("selftest verdict code illegal");
  AST_FAULT_PULL: assert property ((ADJACENT_SHORT_VERDICT == VERDICT_FAIL ||
    DETECTOR_SELFTEST_VERDICT == VERDICT_FAIL) |-> FAULT_N_OE)
    else $error("fault pin not pulled");
  AST_CHECK_TIME: assert property ($fell(SHORT_CHECK_BUSY) |->
    (sel ? (cnt inside {[798:801]}) : (cnt inside {[398:401]})))
    else $error("short check duration wrong");
  AST_VERDICT_HOLD: assert property ((SHORT_CHECK_BUSY && $past(SHORT_CHECK_BUSY))
    |-> $stable(ADJACENT_SHORT_VERDICT))
    else $error("verdict moved during check");
  AST_RESULT_MAP: assert property ($fell(SHORT_CHECK_BUSY) |->
    ADJACENT_SHORT_PER_PIN_RESULT == {SHORT_SENSE_BLUE, SHORT_SENSE_MID, SHORT_SENSE_RED})
    else $error("per pin result mapping wrong");
  AST_FAIL_VERDICT: assert property (($fell(SHORT_CHECK_BUSY) &&
    (|ADJACENT_SHORT_PER_PIN_RESULT)) |-> ADJACENT_SHORT_VERDICT == VERDICT_FAIL)
    else $error("short found but no fail verdict");
  AST_SELFTEST_FAIL: assert property ((SELFTEST_START && !SELFTEST_GOOD) |=>
    DETECTOR_SELFTEST_VERDICT == VERDICT_FAIL ##1 FAULT_N_OE)
    else $error("selftest fail not reported");
  AST_NEGATE_SET: assert property (NEGATE_TOGGLE |=> NEGATE_BIT_A && NEGATE_BIT_B)
    else $error("negate bits not set");
  cover property ($fell(SHORT_CHECK_BUSY) && ADJACENT_SHORT_VERDICT == VERDICT_FAIL);
  cover property ($fell(SHORT_CHECK_BUSY) && sel);
  cover property ($rose(NEGATE_BIT_A));
endmodule // fault_diag_checker

bind led_driver_fault_diagnostics fault_diag_checker #(.RESULT_BITS(RESULT_BITS)) chk (.*);

// File: verif/host_model.sv
`timescale 1ns/1ps
module host_model
  import fault_diag_pkg::*;
(
  input wire logic CLK,
  input wire logic [2:0] req,
  output logic CMD_VALID,
  output logic [11:0] CMD_CODE,
  output logic SHORT_CHECK_START,
  output logic SELFTEST_START,
  output logic NEGATE_TOGGLE
);
  initial begin
    CMD_VALID = 1'b0;
    CMD_CODE = 12'h000;
    SHORT_CHECK_START = 1'b0;
    SELFTEST_START = 1'b0;
    NEGATE_TOGGLE = 1'b0;
  end
  // Idle code inverts each cycle, so after a clear A53h comes back every other cycle with CMD_VALID low
  always @(negedge CLK) begin
    CMD_VALID <= (req == 3'h1);
    CMD_CODE <= (req == 3'h1) ? CMD_ERROR_CLEAR : ~CMD_CODE;
    SHORT_CHECK_START <= (req == 3'h2);
    SELFTEST_START <= (req == 3'h3);
    NEGATE_TOGGLE <= (req == 3'h4);
  end
endmodule // host_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fault_diag_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [2:0] req = 3'h0;
  logic [3:0] cond = 4'h0;
  logic SHORT_CHECK_CURRENT_SEL = 1'b0, SHORT_CHECK_TIME_SEL = 1'b0, SELFTEST_GOOD = 1'b1;
  logic LED_FAULT_MASK = 1'b1, LED_FAULT = 1'b0, GRAYSCALE_CLOCK = 1'b0;
  logic [1:0] GS_MODE = GS_MODE_8;
  logic [7:0] SHORT_SENSE_RED = 8'h00, SHORT_SENSE_MID = 8'h00, SHORT_SENSE_BLUE = 8'h00;
  logic [23:0] OPEN_SENSE = 24'h000000, SHORT_SENSE = 24'h000000, old_open, old_short, pins;
  logic REF_BELOW_LOW, REF_ABOVE_HIGH, TEMP_WARN, TEMP_SHUTDOWN, CMD_VALID, NEGATE_TOGGLE;
  logic SHORT_CHECK_START, SELFTEST_START, SHORT_CHECK_BUSY, SHORT_CHECK_CURRENT_40UA;
  logic [11:0] CMD_CODE;
  logic [2:0] ADJACENT_SHORT_VERDICT, DETECTOR_SELFTEST_VERDICT;
  logic [23:0] ADJACENT_SHORT_PER_PIN_RESULT, OPEN_RESULT_EARLY, SHORT_RESULT_EARLY;
  logic [23:0] OPEN_RESULT_LATE, SHORT_RESULT_LATE;
  logic REF_RESISTOR_SHORT_FLAG, REF_RESISTOR_OPEN_FLAG, CURRENT_FALLBACK, OUTPUTS_ENABLE;
  logic THERMAL_WARNING_FLAG, THERMAL_SHUTDOWN_FLAG, NEGATE_BIT_A, NEGATE_BIT_B;
  logic FAULT_N_OUT, FAULT_N_OE;
  int err_total = 0, checks_done = 0, seed = 15;
  wire [3:0] flags = {THERMAL_SHUTDOWN_FLAG, THERMAL_WARNING_FLAG, REF_RESISTOR_SHORT_FLAG,
    REF_RESISTOR_OPEN_FLAG};
  assign {TEMP_SHUTDOWN, TEMP_WARN, REF_ABOVE_HIGH, REF_BELOW_LOW} = cond;
  led_driver_fault_diagnostics DUT (.*);
  host_model host (.*);
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  ////////////////////////////////////////
  function automatic logic [2:0] exp_verdict(logic [23:0] s);
    return (s != 24'h0) ? VERDICT_FAIL : VERDICT_PASS;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic miss(string n, logic [23:0] e, logic [23:0] s);
    err_total++;
    $display("wrong value %s expected %h seen %h", n, e, s);
  endtask
  task automatic chk_bit(string n, logic e, logic s);
    checks_done++;
    if (s !== e) miss(n, e, s);
  endtask
  task automatic chk_code(string n, logic [2:0] e, logic [2:0] s);
    checks_done++;
    if (s !== e) miss(n, e, s);
  endtask
  task automatic chk_word(string n, logic [23:0] e, logic [23:0] s);
    checks_done++;
    if (s !== e) miss(n, e, s);
  endtask
  // Host side holds the request one cycle, then lets the pulse settle
  task automatic cmd(logic [2:0] k);
    req <= k;
    cyc(1);
    req <= 3'h0;
    cyc(3);
  endtask
  task automatic gs_edges(int n);
    repeat (n) begin
      GRAYSCALE_CLOCK = 1'b1;
      cyc(4);
      GRAYSCALE_CLOCK = 1'b0;
      cyc(4);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(10);
    RST = 1'b0;
    cyc(2);
    chk_code("verdict", VERDICT_RESET, ADJACENT_SHORT_VERDICT);
    chk_word("result", 24'h0, ADJACENT_SHORT_PER_PIN_RESULT);
    chk_bit("ref flags", 1'b0, REF_RESISTOR_SHORT_FLAG | REF_RESISTOR_OPEN_FLAG);
    chk_bit("negate", 1'b0, NEGATE_BIT_A | NEGATE_BIT_B);
    chk_code("selftest", VERDICT_RESET, DETECTOR_SELFTEST_VERDICT);
    chk_bit("fault drive", 1'b0, FAULT_N_OUT);
    $display("test reset done");
    for (int t = 0; t < 2; t++) begin
      SHORT_CHECK_TIME_SEL = t[0];
      SHORT_CHECK_CURRENT_SEL = t[0];
      pins = t[0] ? (24'($random(seed)) | 24'h800001) : 24'h0;
      {SHORT_SENSE_BLUE, SHORT_SENSE_MID, SHORT_SENSE_RED} = pins;
      cmd(3'h2);
      for (int i = 0; i < 900 && SHORT_CHECK_BUSY !== 1'b0; i++) cyc(1);
      if (SHORT_CHECK_BUSY !== 1'b0) begin
        miss("short check busy", 24'h0, 24'h1);
        final_report();
      end
      cyc(1);
      chk_code("verdict", exp_verdict(pins), ADJACENT_SHORT_VERDICT);
      chk_word("result", pins, ADJACENT_SHORT_PER_PIN_RESULT);
      chk_bit("current sel", t[0], SHORT_CHECK_CURRENT_40UA);
      chk_bit("fault pin", t[0], FAULT_N_OE);
    end
    cmd(3'h1);
    chk_code("verdict held", VERDICT_FAIL, ADJACENT_SHORT_VERDICT);
    chk_word("result held", pins, ADJACENT_SHORT_PER_PIN_RESULT);
    chk_bit("fault held", 1'b1, FAULT_N_OE);
    {SHORT_SENSE_BLUE, SHORT_SENSE_MID, SHORT_SENSE_RED} = 24'h0;
    cmd(3'h1);
    chk_code("verdict clr", VERDICT_RESET, ADJACENT_SHORT_VERDICT);
    chk_word("result clr", 24'h0, ADJACENT_SHORT_PER_PIN_RESULT);
    chk_bit("fault pin", 1'b0, FAULT_N_OE);
    $display("test short check done");
    for (int i = 0; i < 4; i++) begin
      cond[i] = 1'b1;
      cyc(8);
      chk_bit("flag set", 1'b1, flags[i]);
      chk_bit("fault pin", 1'b1, FAULT_N_OE);
      chk_bit("fallback", i < 2, CURRENT_FALLBACK);
      chk_bit("outputs", i != 3, OUTPUTS_ENABLE);
      cmd(3'h1);
      chk_bit("flag held", 1'b1, flags[i]);
      cond[i] = 1'b0;
      cyc(8);
      chk_bit("fallback off", 1'b0, CURRENT_FALLBACK);
      chk_bit("outputs back", 1'b1, OUTPUTS_ENABLE);
      chk_bit("flag kept", 1'b1, flags[i]);
      cmd(3'h1);
      chk_bit("flag clr", 1'b0, flags[i]);
      chk_bit("fault pin", 1'b0, FAULT_N_OE);
    end
    $display("test ref and thermal done");
    cmd(3'h3);
    chk_code("selftest", VERDICT_PASS, DETECTOR_SELFTEST_VERDICT);
    cmd(3'h1);
    chk_code("selftest pass clr", VERDICT_RESET, DETECTOR_SELFTEST_VERDICT);
    SELFTEST_GOOD = 1'b0;
    cmd(3'h3);
    cmd(3'h1);
    chk_code("selftest held", VERDICT_FAIL, DETECTOR_SELFTEST_VERDICT);
    chk_bit("fault pin", 1'b1, FAULT_N_OE);
    SELFTEST_GOOD = 1'b1;
    cmd(3'h1);
    chk_code("selftest clr", VERDICT_RESET, DETECTOR_SELFTEST_VERDICT);
    LED_FAULT = 1'b1;
    cyc(3);
    chk_bit("masked led", 1'b0, FAULT_N_OE);
    LED_FAULT_MASK = 1'b0;
    cyc(3);
    chk_bit("unmasked led", 1'b1, FAULT_N_OE);
    LED_FAULT = 1'b0;
    LED_FAULT_MASK = 1'b1;
    $display("test selftest and mask done");
    // One full 8-bit period per pass; sense changes between the two latch edges
    for (int n = 0; n < 2; n++) begin
      if (n == 1) cmd(3'h4);
      old_open = 24'($random(seed));
      old_short = 24'($random(seed));
      OPEN_SENSE = old_open;
      SHORT_SENSE = old_short;
      gs_edges(20);
      OPEN_SENSE = 24'($random(seed));
      SHORT_SENSE = 24'($random(seed));
      gs_edges(236);
      cyc(8);
      chk_word("open early", old_open ^ {24{n[0]}}, OPEN_RESULT_EARLY);
      chk_word("short early", old_short ^ {24{n[0]}}, SHORT_RESULT_EARLY);
      chk_word("open late", OPEN_SENSE ^ {24{n[0]}}, OPEN_RESULT_LATE);
      chk_word("short late", SHORT_SENSE ^ {24{n[0]}}, SHORT_RESULT_LATE);
      chk_bit("negate set", n[0], NEGATE_BIT_A & NEGATE_BIT_B);
    end
    $display("test grayscale latch done");
    // Wider modes: edge 255 must not latch the late set, only the longer period's end
    for (int m = 0; m < 2; m++) begin
      GS_MODE = (m == 0) ? GS_MODE_10 : GS_MODE_12;
      old_open = OPEN_SENSE ^ 24'hFFFFFF;
      OPEN_SENSE = 24'($random(seed));
      gs_edges(255);
      chk_word("open late wait", old_open, OPEN_RESULT_LATE);
      gs_edges((m == 0) ? 769 : 3841);
      cyc(8);
      chk_word("open late wide", OPEN_SENSE ^ 24'hFFFFFF, OPEN_RESULT_LATE);
    end
    $display("test grayscale modes done");
    final_report();
  end
endmodule // tb_top
